// file: pllrs_core.sv
// reference switchover, R and N dividers, pump controls and APB registers
//
// Added by the designer: the placing of the registers and the APB slave port.
module pllrs_core (
    input  wire logic                  mclk_in,
    input  wire logic                  reset_in,
    input  wire logic                  ce_in,
    input  wire logic                  psel_in,
    input  wire logic                  penable_in,
    input  wire logic                  pwrite_in,
    input  wire logic [11:0]           paddr_in,
    input  wire logic [31:0]           pwdata_in,
    output logic      [31:0]           prdata_out,
    output logic                       pready_out,
    output logic                       pslverr_out,
    input  wire logic                  primary_reference_in,
    input  wire logic                  secondary_reference_in,
    input  wire logic                  feedback_in,
    input  wire logic                  ref_select_pin_in,
    input  wire logic                  sync_n_in,
    output logic                       pfd_ref_pulse_out,
    output logic                       pfd_fb_pulse_out,
    output logic                       loop_ref_out,
    output logic                       on_secondary_out,
    output pllrs_pkg::pllrs_pump_s     pump_out,
    output pllrs_pkg::pllrs_pwr_s      pwr_out
);
    // ************************************
    // pin synchronisers
    // ************************************
    localparam int NP = 5;
    // sync_n idles high, so the whole chain resets to that level and no false sync follows reset
    localparam logic [NP-1:0] PIN_IDLE = 5'h10;
    logic [NP-1:0] pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_q_ff, pin_prev_ff;
    logic [NP-1:0] nxt_pin_q;
    logic          prim_rise, prim_edge, sec_rise, sec_fall, fb_rise;

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            pin_s1_ff <= PIN_IDLE;
            pin_s2_ff <= PIN_IDLE;
            pin_s3_ff <= PIN_IDLE;
        end else if (ce_in) begin
            pin_s1_ff <= {sync_n_in, ref_select_pin_in, feedback_in,
                          secondary_reference_in, primary_reference_in};
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
        end
    end

    // a level is taken only once stages two and three agree
    always_comb begin
        for (int i = 0; i < NP; i++) begin
            nxt_pin_q[i] = (pin_s2_ff[i] == pin_s3_ff[i]) ? pin_s3_ff[i] : pin_q_ff[i];
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            pin_q_ff    <= PIN_IDLE;
            pin_prev_ff <= PIN_IDLE;
        end else if (ce_in) begin
            pin_q_ff    <= nxt_pin_q;
            pin_prev_ff <= pin_q_ff;
        end
    end

    assign prim_rise = pin_q_ff[0] & ~pin_prev_ff[0];
    assign prim_edge = pin_q_ff[0] ^ pin_prev_ff[0];
    assign sec_rise  = pin_q_ff[1] & ~pin_prev_ff[1];
    assign sec_fall  = ~pin_q_ff[1] & pin_prev_ff[1];
    assign fb_rise   = pin_q_ff[2] & ~pin_prev_ff[2];

    // ************************************
    // APB registers
    // ************************************
    logic [7:0] pll_ctrl_ff, r_lo_ff, r_hi_ff, a_ff, b_lo_ff, b_hi_ff;
    logic [7:0] presc_ff, pfd_ff, sync_ff, ref_ctrl_ff, status;
    logic [7:0] idx, rd_byte;
    logic       hit, wr_go;

    assign idx   = paddr_in[9:2];
    assign wr_go = psel_in & penable_in & pready_out & pwrite_in & hit;

    always_comb begin
        hit     = 1'b1;
        rd_byte = 8'h00;
        case (idx)
            pllrs_pkg::IDX_PLL_CTRL: rd_byte = pll_ctrl_ff;
            pllrs_pkg::IDX_R_LO:     rd_byte = r_lo_ff;
            pllrs_pkg::IDX_R_HI:     rd_byte = r_hi_ff;
            pllrs_pkg::IDX_A_CNT:    rd_byte = a_ff;
            pllrs_pkg::IDX_B_LO:     rd_byte = b_lo_ff;
            pllrs_pkg::IDX_B_HI:     rd_byte = b_hi_ff;
            pllrs_pkg::IDX_PRESC:    rd_byte = presc_ff;
            pllrs_pkg::IDX_PFD:      rd_byte = pfd_ff;
            pllrs_pkg::IDX_SYNC:     rd_byte = sync_ff;
            pllrs_pkg::IDX_REF_CTRL: rd_byte = ref_ctrl_ff;
            pllrs_pkg::IDX_STATUS:   rd_byte = status;
            default:                 hit = 1'b0;
        endcase
        if (paddr_in[11:10] != 2'h0 || paddr_in[1:0] != 2'h0) begin
            hit = 1'b0;
        end
    end

    // no wait state: pready and read data are registered in the setup cycle
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0000_0000;
        end else if (ce_in) begin
            pready_out  <= psel_in & ~penable_in;
            pslverr_out <= psel_in & ~penable_in & ~hit;
            if (psel_in & ~penable_in & ~pwrite_in) begin
                prdata_out <= {24'h00_0000, hit ? rd_byte : 8'h00};
            end
        end
    end

    // buffers all start off, loop starts powered down
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            pll_ctrl_ff <= pllrs_pkg::RST_PLL_CTRL;
            r_lo_ff     <= pllrs_pkg::RST_ZERO;
            r_hi_ff     <= pllrs_pkg::RST_ZERO;
            a_ff        <= pllrs_pkg::RST_ZERO;
            b_lo_ff     <= pllrs_pkg::RST_ZERO;
            b_hi_ff     <= pllrs_pkg::RST_ZERO;
            presc_ff    <= pllrs_pkg::RST_ZERO;
            pfd_ff      <= pllrs_pkg::RST_ZERO;
            sync_ff     <= pllrs_pkg::RST_ZERO;
            ref_ctrl_ff <= pllrs_pkg::RST_ZERO;
        end else if (ce_in && wr_go) begin
            case (idx)
                pllrs_pkg::IDX_PLL_CTRL: pll_ctrl_ff <= pwdata_in[7:0];
                pllrs_pkg::IDX_R_LO:     r_lo_ff     <= pwdata_in[7:0];
                pllrs_pkg::IDX_R_HI:     r_hi_ff     <= {2'h0, pwdata_in[5:0]};
                pllrs_pkg::IDX_A_CNT:    a_ff        <= {2'h0, pwdata_in[5:0]};
                pllrs_pkg::IDX_B_LO:     b_lo_ff     <= pwdata_in[7:0];
                pllrs_pkg::IDX_B_HI:     b_hi_ff     <= {3'h0, pwdata_in[4:0]};
                pllrs_pkg::IDX_PRESC:    presc_ff    <= pwdata_in[7:0];
                pllrs_pkg::IDX_PFD:      pfd_ff      <= {6'h00, pwdata_in[1:0]};
                pllrs_pkg::IDX_SYNC:     sync_ff     <= {pwdata_in[7:6], 6'h00};
                pllrs_pkg::IDX_REF_CTRL: ref_ctrl_ff <= pwdata_in[7:0];
                default: ;
            endcase
        end
    end

    // ************************************
    // reference selection
    // ************************************
    logic       auto_mode, no_revert, dg_off, man_sec, pll_on;
    logic [1:0] miss_cnt_ff, back_sec_cnt_ff;
    logic [2:0] back_cnt_ff;
    logic       missing_ff, want_sec_ff, hold_sec_ff, act_sec_ff, target_sec;

    assign auto_mode = ref_ctrl_ff[pllrs_pkg::AUTO_BIT];
    assign no_revert = ref_ctrl_ff[pllrs_pkg::NOREV_BIT];
    assign dg_off    = ref_ctrl_ff[pllrs_pkg::DGDIS_BIT];
    assign man_sec   = ref_ctrl_ff[pllrs_pkg::PINSEL_BIT] ? pin_q_ff[3]
                                                          : ref_ctrl_ff[pllrs_pkg::MSEL_BIT];
    assign pll_on    = pll_ctrl_ff[pllrs_pkg::PWR_LSB +: 2] == pllrs_pkg::PWR_NORMAL;

    // secondary falls since the last primary edge
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            miss_cnt_ff <= 2'h0;
            missing_ff  <= 1'b0;
        end else if (ce_in) begin
            if (prim_edge) begin
                miss_cnt_ff <= 2'h0;
                missing_ff  <= 1'b0;
            end else if (sec_fall && miss_cnt_ff != 2'(pllrs_pkg::MISS_FALLS)) begin
                miss_cnt_ff <= miss_cnt_ff + 2'h1;
                if (miss_cnt_ff == 2'(pllrs_pkg::MISS_FALLS - 1)) begin
                    missing_ff <= 1'b1;
                end
            end
        end
    end

    // primary rises counted toward return, cleared by two secondary falls
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            back_cnt_ff     <= 3'h0;
            back_sec_cnt_ff <= 2'h0;
        end else if (ce_in) begin
            if (prim_rise) begin
                back_sec_cnt_ff <= 2'h0;
                if (back_cnt_ff != 3'(pllrs_pkg::BACK_RISES)) begin
                    back_cnt_ff <= back_cnt_ff + 3'h1;
                end
            end else if (sec_fall) begin
                if (back_sec_cnt_ff == 2'(pllrs_pkg::MISS_FALLS - 1)) begin
                    back_cnt_ff     <= 3'h0;
                    back_sec_cnt_ff <= 2'h0;
                end else begin
                    back_sec_cnt_ff <= back_sec_cnt_ff + 2'h1;
                end
            end
        end
    end

    // hold_sec latches the no-revert stay; leaving auto on primary frees it
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            want_sec_ff <= 1'b0;
            hold_sec_ff <= 1'b0;
        end else if (ce_in) begin
            if (!auto_mode) begin
                want_sec_ff <= man_sec;
                if (!man_sec && !act_sec_ff) begin
                    hold_sec_ff <= 1'b0;
                end
            end else if (missing_ff) begin
                want_sec_ff <= 1'b1;
                hold_sec_ff <= no_revert;
            end else if (back_cnt_ff == 3'(pllrs_pkg::BACK_RISES) && !no_revert && !hold_sec_ff) begin
                want_sec_ff <= 1'b0;
            end
        end
    end

    assign target_sec = auto_mode ? (want_sec_ff | hold_sec_ff) : want_sec_ff;

    // the change is made on the target's rising edge, so no short pulse reaches the loop
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            act_sec_ff <= 1'b0;
        end else if (ce_in && target_sec != act_sec_ff) begin
            if (dg_off) begin
                act_sec_ff <= target_sec;
            end else if (target_sec ? sec_rise : prim_rise) begin
                act_sec_ff <= target_sec;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            loop_ref_out     <= 1'b0;
            on_secondary_out <= 1'b0;
        end else if (ce_in) begin
            loop_ref_out     <= act_sec_ff ? pin_q_ff[1] : pin_q_ff[0];
            on_secondary_out <= act_sec_ff;
        end
    end

    assign status = {5'h00, target_sec != act_sec_ff, missing_ff, act_sec_ff};

    // ************************************
    // power and pump controls
    // ************************************
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            pwr_out  <= '0;
            pump_out <= '{pllrs_pkg::PLLRS_CP_HIZ, 3'h0, 2'h0};
        end else if (ce_in) begin
            pwr_out.diff_rx_on   <= pll_on & ref_ctrl_ff[pllrs_pkg::DIFF_BIT];
            pwr_out.primary_on   <= pll_on & ~ref_ctrl_ff[pllrs_pkg::DIFF_BIT]
                                    & ref_ctrl_ff[pllrs_pkg::PEN_BIT];
            pwr_out.secondary_on <= pll_on & ~ref_ctrl_ff[pllrs_pkg::DIFF_BIT]
                                    & ref_ctrl_ff[pllrs_pkg::SEN_BIT];
            pump_out.mode         <= pllrs_pkg::pllrs_cpm_e'(pll_ctrl_ff[pllrs_pkg::CPM_LSB +: 2]);
            pump_out.current      <= pll_ctrl_ff[pllrs_pkg::CPI_LSB +: 3];
            pump_out.antibacklash <= pfd_ff[pllrs_pkg::ABL_LSB +: 2];
        end
    end

    // ************************************
    // R and N dividers
    // ************************************
    logic [13:0]          r_set, r_cnt_ff;
    logic [12:0]          b_set;
    logic [pllrs_pkg::N_W-1:0] n_cnt_ff, n_set;
    logic                 sync_rst, r_rst, ab_rst;

    // prescaler code: 0..4 dual modulus 2..32, 5..7 fixed 1..3
    function automatic logic [5:0] presc_p(input logic [2:0] code);
        case (code)
            3'h5:    presc_p = 6'h01;
            3'h6:    presc_p = 6'h02;
            3'h7:    presc_p = 6'h03;
            default: presc_p = 6'(6'h02 << code);
        endcase
    endfunction

    function automatic logic [pllrs_pkg::N_W-1:0] n_total(input logic [2:0] code,
            input logic [12:0] b, input logic [5:0] a, input logic byp);
        logic [pllrs_pkg::N_W-1:0] pb;
        pb = pllrs_pkg::N_W'(presc_p(code)) * pllrs_pkg::N_W'(byp ? 13'h0001 : b);
        if (code >= 3'h5 || byp) begin
            n_total = pb;
        end else begin
            n_total = pb + pllrs_pkg::N_W'(a);
        end
    endfunction

    assign r_set    = {r_hi_ff[5:0], r_lo_ff};
    assign b_set    = {b_hi_ff[4:0], b_lo_ff};
    assign n_set    = n_total(presc_ff[pllrs_pkg::PRE_LSB +: 3], b_set, a_ff[5:0],
                              presc_ff[pllrs_pkg::BYP_BIT]);
    assign sync_rst = (sync_ff[pllrs_pkg::SYNC_LSB +: 2] != pllrs_pkg::SYNC_OFF) & ~pin_q_ff[4];
    assign r_rst    = presc_ff[pllrs_pkg::RRST_BIT] | presc_ff[pllrs_pkg::ALLRST_BIT] | sync_rst;
    assign ab_rst   = presc_ff[pllrs_pkg::ABRST_BIT] | presc_ff[pllrs_pkg::ALLRST_BIT] | sync_rst;

    // one pulse per r_set loop-reference rises; 0 and 1 both give every rise
    always_ff @(posedge mclk_in) begin
        if (reset_in || r_rst) begin
            r_cnt_ff          <= 14'h0000;
            pfd_ref_pulse_out <= 1'b0;
        end else if (ce_in) begin
            pfd_ref_pulse_out <= 1'b0;
            if (act_sec_ff ? sec_rise : prim_rise) begin
                if (r_cnt_ff + 14'h0001 >= r_set) begin
                    r_cnt_ff          <= 14'h0000;
                    pfd_ref_pulse_out <= 1'b1;
                end else begin
                    r_cnt_ff <= r_cnt_ff + 14'h0001;
                end
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in || ab_rst) begin
            n_cnt_ff         <= '0;
            pfd_fb_pulse_out <= 1'b0;
        end else if (ce_in) begin
            pfd_fb_pulse_out <= 1'b0;
            if (fb_rise) begin
                if (n_cnt_ff + 1'b1 >= n_set) begin
                    n_cnt_ff         <= '0;
                    pfd_fb_pulse_out <= 1'b1;
                end else begin
                    n_cnt_ff <= n_cnt_ff + 1'b1;
                end
            end
        end
    end

    // ************************************
    // assertions
    // ************************************
    default clocking @(posedge mclk_in); endclocking
    default disable iff (reset_in || !ce_in);

    a_miss_two_falls: assert property ($rose(missing_ff) |-> $past(sec_fall) && !$past(prim_edge))
        else $error("missing set without secondary fall");
    a_switch_sec_rise: assert property ($rose(act_sec_ff) && !dg_off |-> $past(sec_rise))
        else $error("secondary taken off its rising edge");
    a_norevert_hold: assert property (auto_mode && no_revert && act_sec_ff && hold_sec_ff
        && $stable(ref_ctrl_ff) |=> act_sec_ff)
        else $error("left secondary with no-revert set");
    a_return_edge: assert property ($fell(act_sec_ff) && !dg_off |-> $past(prim_rise))
        else $error("primary taken off its rising edge");
    a_diff_blocks_se: assert property (ref_ctrl_ff[pllrs_pkg::DIFF_BIT] |=>
        !pwr_out.primary_on && !pwr_out.secondary_on)
        else $error("single-ended buffer on in differential mode");
    a_pll_off_power: assert property (!pll_on |=> pwr_out == '0)
        else $error("receiver on with loop down");
    a_reset_buf_off: assert property (@(posedge mclk_in) disable iff (1'b0)
        $past(reset_in) |-> pwr_out == '0)
        else $error("buffer on after reset");
    a_r_div_one: assert property (r_set <= 14'h0001 && !r_rst && (act_sec_ff ? sec_rise : prim_rise)
        |=> pfd_ref_pulse_out)
        else $error("divide by one missed a pulse");
    a_r_reset_hold: assert property (r_rst |=> r_cnt_ff == 14'h0000 && !pfd_ref_pulse_out)
        else $error("reference divider ran in reset");
    a_ab_reset_hold: assert property (ab_rst |=> n_cnt_ff == '0 ##1 (n_cnt_ff == '0 || !ab_rst))
        else $error("feedback divider ran in reset");
    a_pump_mode: assert property ($changed(pll_ctrl_ff) |=>
        pump_out.mode == pllrs_pkg::pllrs_cpm_e'($past(pll_ctrl_ff[pllrs_pkg::CPM_LSB +: 2])))
        else $error("pump mode not following register");

    c_auto_to_sec: cover property (auto_mode && $rose(act_sec_ff));
    c_auto_back:   cover property (auto_mode && $fell(act_sec_ff));
    c_fb_pulse:    cover property (pfd_fb_pulse_out ##[1:50] pfd_ref_pulse_out);
endmodule // pllrs_core

// file: pllrs_pkg.sv
// constants, types and register map of the reference switch and divider block
//
// Functional notes
// - two secondary falls without primary edge: missing
// - move to secondary on next secondary rise
// - revert after four primary rises, unless interrupted
// - no-revert holds secondary until manual primary
// - automatic mode re-enabled once primary reselected
// - manual switch needs toggling target or deglitch-off
// - switch only at target rising edge
// - all reference buffers off after reset
// - power down receivers with loop or bits
// - differential mode powers down single-ended buffers
// - two-bit charge pump mode selects four modes
// - three-bit pump current code, eight steps
// - two-bit antibacklash width field
// - fourteen-bit reference divider over two bytes
// - reference divide of zero or one divides one
// - reference divider reset: own, shared, sync
// - feedback division is P times B plus A
// - prescaler field: fixed 1/2/3 or dual modulus
// - fixed divide modes ignore the A count
// - B three or more or bypassed; A=0 true zero; the code takes any B, B_MIN is not checked
// - B bypassed: division equals prescaler alone
// - A/B own and shared reset, not self-clearing
// - sync pin resets R, A, B when enabled
package pllrs_pkg;
    // ************************************
    // register indices, byte address = index * 4
    // ************************************
    localparam logic [7:0] IDX_PLL_CTRL = 8'h10;
    localparam logic [7:0] IDX_R_LO     = 8'h11;
    localparam logic [7:0] IDX_R_HI     = 8'h12;
    localparam logic [7:0] IDX_A_CNT    = 8'h13;
    localparam logic [7:0] IDX_B_LO     = 8'h14;
    localparam logic [7:0] IDX_B_HI     = 8'h15;
    localparam logic [7:0] IDX_PRESC    = 8'h16;
    localparam logic [7:0] IDX_PFD      = 8'h17;
    localparam logic [7:0] IDX_SYNC     = 8'h19;
    localparam logic [7:0] IDX_REF_CTRL = 8'h1C;
    localparam logic [7:0] IDX_STATUS   = 8'h1F;
    // ************************************
    // field positions
    // ************************************
    localparam int PWR_LSB    = 0;
    localparam int CPM_LSB    = 2;
    localparam int CPI_LSB    = 4;
    localparam int PRE_LSB    = 0;
    localparam int BYP_BIT    = 3;
    localparam int RRST_BIT   = 4;
    localparam int ABRST_BIT  = 5;
    localparam int ALLRST_BIT = 6;
    localparam int ABL_LSB    = 0;
    localparam int SYNC_LSB   = 6;
    localparam int DIFF_BIT   = 0;
    localparam int PEN_BIT    = 1;
    localparam int SEN_BIT    = 2;
    localparam int NOREV_BIT  = 3;
    localparam int AUTO_BIT   = 4;
    localparam int MSEL_BIT   = 5;
    localparam int PINSEL_BIT = 6;
    localparam int DGDIS_BIT  = 7;
    // ************************************
    // reset values and codes
    // ************************************
    localparam logic [7:0] RST_PLL_CTRL = 8'h01;
    localparam logic [7:0] RST_ZERO     = 8'h00;
    localparam logic [1:0] PWR_NORMAL   = 2'h0;
    localparam logic [1:0] SYNC_OFF     = 2'h0;
    localparam int         MISS_FALLS   = 2;
    localparam int         BACK_RISES   = 4;
    localparam int         B_MIN        = 3;
    localparam int         N_W          = 19;

    typedef enum logic [1:0] {
        PLLRS_CP_HIZ,
        PLLRS_CP_NORMAL,
        PLLRS_CP_UP,
        PLLRS_CP_DOWN
    } pllrs_cpm_e;

    typedef struct packed {
        pllrs_cpm_e mode;
        logic [2:0] current;
        logic [1:0] antibacklash;
    } pllrs_pump_s;

    typedef struct packed {
        logic diff_rx_on;
        logic primary_on;
        logic secondary_on;
    } pllrs_pwr_s;
endpackage : pllrs_pkg

// file: pllrs_ref_src.sv
// model of the two reference sources and the feedback oscillator
module pllrs_ref_src (
    input  wire logic en_pri_in,
    input  wire logic en_sec_in,
    input  wire logic en_fb_in,
    output logic      pri_out,
    output logic      sec_out,
    output logic      fb_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {pri_out, sec_out, fb_out} = 3'h0;
    end
    // periods unrelated to the bench clock; a stopped source stands at its last level
    always #113.7 if (en_pri_in) pri_out = ~pri_out;
    always #137.3 if (en_sec_in) sec_out = ~sec_out;
    always #101.1 if (en_fb_in) fb_out = ~fb_out;
endmodule // pllrs_ref_src

// file: tb_pll_ref_switch_and_dividers.sv
// self-checking bench for the reference switch and divider block
module tb_pll_ref_switch_and_dividers;
    timeunit 1ns;
    timeprecision 100ps;
    logic                   mclk_in, reset_in, psel, penable, pwrite, pready, pslverr, rerr, sync_n, ref_sel;
    logic                   pri, sec, fb, ref_p, fb_p, loop_ref, on_sec, en_pri, en_sec, en_fb;
    logic [11:0]            paddr;
    logic [31:0]            pwdata, prdata, rdat;
    pllrs_pkg::pllrs_pump_s pump;
    pllrs_pkg::pllrs_pwr_s  pwr;
    int                     err_total, checks, cyc, n_pri, n_fb;
    logic [13:0]            rv[4] = '{14'h0000, 14'h0001, 14'h0003, 14'h0102};
    int                     rx[4] = '{1, 1, 3, 258};
    logic [7:0]             nv[4][2] = '{'{8'h00, 8'h01}, '{8'h01, 8'h00}, '{8'h06, 8'h01}, '{8'h08, 8'h00}};
    int                     nx[4] = '{7, 12, 6, 2};

    pllrs_ref_src src (.en_pri_in(en_pri), .en_sec_in(en_sec), .en_fb_in(en_fb),
        .pri_out(pri), .sec_out(sec), .fb_out(fb));
    pllrs_core dut (.mclk_in(mclk_in), .reset_in(reset_in), .ce_in(1'b1), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .primary_reference_in(pri),
        .secondary_reference_in(sec), .feedback_in(fb), .ref_select_pin_in(ref_sel), .sync_n_in(sync_n),
        .pfd_ref_pulse_out(ref_p), .pfd_fb_pulse_out(fb_p), .loop_ref_out(loop_ref),
        .on_secondary_out(on_sec), .pump_out(pump), .pwr_out(pwr));

    initial begin
        mclk_in = 1'b0;
        forever #12.5 mclk_in = ~mclk_in;
    end
    always @(posedge pri) n_pri++;
    always @(posedge fb) n_fb++;
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            end_sim();
        end
    end

    // ************************************
    // bus and compare helpers
    // ************************************
    task automatic end_sim;
        if (err_total == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
    endtask
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge mclk_in);
        {psel, penable, pwrite} <= {1'b1, 1'b0, wr};
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge mclk_in);
        penable <= 1'b1;
        @(posedge mclk_in);
        while (pready !== 1'b1) @(posedge mclk_in);
        rdat = prdata;
        rerr = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task automatic wait_sec(input logic v, input string nm);
        for (int i = 0; i < 400 && on_sec !== v; i++) @(posedge mclk_in);
        chk(nm, on_sec, v);
    endtask
    // source rises between two consecutive divider pulses
    task automatic meas(input logic use_fb, input int n, input string nm);
        for (int i = 0; i < 2; i++) begin
            @(posedge mclk_in);
            while ((use_fb ? fb_p : ref_p) !== 1'b1) @(posedge mclk_in);
            if (i == 0) {n_pri, n_fb} = 64'h0;
        end
        chk(nm, use_fb ? n_fb : n_pri, n);
    endtask

    // ************************************
    // main sequence
    // ************************************
    initial begin
        {reset_in, psel, penable, pwrite, en_pri, en_sec, en_fb} = 7'h47;
        {sync_n, ref_sel} = 2'h2;
        {paddr, pwdata} = 44'h0;
        {err_total, checks, cyc, n_pri, n_fb} = 160'h0;
        tick(20);
        reset_in <= 1'b0;
        tick(1);
        chk("pwr_reset", pwr, 3'h0);
        chk("pump_reset", pump, 7'h00);
        apb(0, pllrs_pkg::IDX_PLL_CTRL, 8'h00);
        chk("pll_ctrl_reset", rdat, {24'h0, pllrs_pkg::RST_PLL_CTRL});
        apb(0, 8'h18, 8'h00);
        chk("unmapped", {rerr, rdat[30:0]}, 32'h8000_0000);
        for (int i = 0; i < 4; i++) begin
            apb(1, pllrs_pkg::IDX_PLL_CTRL, {1'b0, 3'(2 * i + 1), 2'(i), 2'h0});
            apb(1, pllrs_pkg::IDX_PFD, 8'(i));
            tick(2);
            chk("pump", pump, {2'(i), 3'(2 * i + 1), 2'(i)});
        end
        apb(1, pllrs_pkg::IDX_REF_CTRL, 8'h07);
        tick(2);
        chk("pwr_diff", pwr, 3'h4);
        apb(1, pllrs_pkg::IDX_PLL_CTRL, 8'h01);
        tick(2);
        chk("pwr_loop_off", pwr, 3'h0);
        apb(1, pllrs_pkg::IDX_PLL_CTRL, 8'h04);
        apb(1, pllrs_pkg::IDX_REF_CTRL, 8'h06);
        tick(2);
        chk("pwr_single", pwr, 3'h3);
        // counters held in reset while reloaded, so each ratio starts clean
        for (int i = 0; i < 4; i++) begin
            apb(1, pllrs_pkg::IDX_PRESC, 8'h70);
            apb(1, pllrs_pkg::IDX_R_LO, rv[i][7:0]);
            apb(1, pllrs_pkg::IDX_R_HI, {2'h0, rv[i][13:8]});
            apb(1, pllrs_pkg::IDX_PRESC, 8'h00);
            meas(1'b0, rx[i], "r_div");
        end
        apb(1, pllrs_pkg::IDX_PRESC, 8'h70);
        apb(0, pllrs_pkg::IDX_PRESC, 8'h00);
        chk("rst_bits_stay", rdat, 32'h0000_0070);
        for (int i = 0; i < 4; i++) begin
            apb(1, pllrs_pkg::IDX_PRESC, 8'h70);
            apb(1, pllrs_pkg::IDX_A_CNT, nv[i][1]);
            apb(1, pllrs_pkg::IDX_B_LO, 8'h03);
            apb(1, pllrs_pkg::IDX_B_HI, 8'h00);
            apb(1, pllrs_pkg::IDX_PRESC, nv[i][0]);
            meas(1'b1, nx[i], "n_div");
        end
        sync_n <= 1'b0;
        meas(1'b1, 2, "sync_off");
        apb(1, pllrs_pkg::IDX_SYNC, 8'hC0);
        tick(8);
        rdat = 32'h0;
        repeat (100) begin
            @(posedge mclk_in);
            rdat[0] = rdat[0] | fb_p;
        end
        chk("sync_hold", rdat[0], 1'b0);
        sync_n <= 1'b1;
        apb(1, pllrs_pkg::IDX_SYNC, 8'h00);
        apb(1, pllrs_pkg::IDX_REF_CTRL, 8'h16);
        en_pri <= 1'b0;
        wait_sec(1'b1, "auto_to_sec");
        apb(0, pllrs_pkg::IDX_STATUS, 8'h00);
        chk("status", rdat[1:0], 2'h3);
        en_pri <= 1'b1;
        wait_sec(1'b0, "revert");
        apb(1, pllrs_pkg::IDX_REF_CTRL, 8'h1E);
        en_pri <= 1'b0;
        wait_sec(1'b1, "norev_sec");
        en_pri <= 1'b1;
        tick(300);
        chk("norev_hold", on_sec, 1'b1);
        apb(1, pllrs_pkg::IDX_REF_CTRL, 8'h06);
        wait_sec(1'b0, "manual_primary");
        apb(1, pllrs_pkg::IDX_REF_CTRL, 8'h16);
        tick(100);
        chk("auto_again", on_sec, 1'b0);
        en_sec <= 1'b0;
        apb(1, pllrs_pkg::IDX_REF_CTRL, 8'h26);
        tick(100);
        chk("quiet_target", on_sec, 1'b0);
        apb(1, pllrs_pkg::IDX_REF_CTRL, 8'hA6);
        wait_sec(1'b1, "deglitch_off");
        chk("loop_ref_held", loop_ref, sec);
        en_sec <= 1'b1;
        apb(1, pllrs_pkg::IDX_REF_CTRL, 8'h46);
        wait_sec(1'b0, "pin_primary");
        ref_sel <= 1'b1;
        wait_sec(1'b1, "pin_secondary");
        end_sim();
    end
endmodule // tb_pll_ref_switch_and_dividers
